/* File: sensor_maint_defines.vh */
// Constants for the sensor maintenance command handler.
// Assumes a byte-wide serial receiver and transmitter outside the block.
`ifndef SENSOR_MAINT_DEFINES_VH
`define SENSOR_MAINT_DEFINES_VH

// Frame prefixes
`define PFX_LONG 8'hac
`define PFX_EXT 8'haf
`define PFX_VAR 8'ha0
// Argument bytes
`define ARG_COMMIT 8'h00
`define ARG_ALLOW 8'h01
`define ARG_BREAK 8'h02
`define ARG_RESET 8'h03
`define ARG_PING 8'hb7
`define ARG_EMUL_OFF 8'hc2
`define ARG_EMUL_ON 8'hc3
`define ARG_DELAY 8'hcd
// Broadcast identification frame fields
`define BCAST_ADDR 8'h03
`define PING_BC_CHK 8'h98
// Address layout: unit id above two axis bits
`define AXIS_BOTH 2'h3
// Single-byte answers
`define ACK_BYTE 8'h06
`define NAK_BYTE 8'h15
// Factory values
`define FACTORY_DELAY 8'h00
// Timing: delay units per second (one unit is 1/32.768 ms)
`define DELAY_UNITS_PER_S 32768
`define BREAK_WINDOW_US 28000
`define COMMIT_TIME_US 32000
// Identification reply layout
`define PING_LAST 4'hb
`define CFG_EMUL_BIT 7

`endif

/* File: sensor_maintenance_command_handler.v */
// Maintenance command handler: frame parser, configuration segments,
// startup break window, identification, reset and protected commit.
// Assumes a byte receiver/transmitter outside; tx bytes use valid/ready.
`include "sensor_maint_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module sensor_maintenance_command_handler #(
  parameter CLK_HZ = 125000000,
  parameter WINDOW_CYCLES = `BREAK_WINDOW_US * (CLK_HZ / 1000000),
  parameter COMMIT_CYCLES = `COMMIT_TIME_US * (CLK_HZ / 1000000),
  parameter FACTORY_EMUL = 1'b0
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Received bytes
  input wire [7:0] rx_data,
  input wire rx_valid,
  // Reply bytes
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  // Unit identity
  input wire [5:0] unit_id,
  // Operating state
  output reg streaming,
  output reg temporary_half_duplex_mode,
  output reg line_emul,
  output reg [7:0] resp_delay,
  output reg commit_busy
);

  localparam [2:0] P_IDLE = 3'h0;
  localparam [2:0] P_ADDR = 3'h1;
  localparam [2:0] P_ARG = 3'h2;
  localparam [2:0] P_PARAM = 3'h3;
  localparam [2:0] P_CHK = 3'h4;

  localparam [1:0] R_IDLE = 2'h0;
  localparam [1:0] R_FLASH = 2'h1;
  localparam [1:0] R_DELAY = 2'h2;
  localparam [1:0] R_SEND = 2'h3;

  localparam [39:0] CLK40 = CLK_HZ;
  localparam [39:0] UNIT_ROUND = `DELAY_UNITS_PER_S - 1;
  localparam [31:0] WIN32 = WINDOW_CYCLES;
  localparam [31:0] COMMIT32 = COMMIT_CYCLES;

  // Configuration segments
  reg [7:0] prim_delay;
  reg prim_emul;
  reg [7:0] edit_delay;
  reg edit_emul;

  // Parser
  reg [2:0] pstate;
  reg p_ext;
  reg [7:0] p_addr;
  reg [7:0] p_arg;
  reg [7:0] p_param;
  reg [7:0] p_sum;

  // Mode and sequencing
  reg window_open;
  reg [31:0] win_cnt;
  reg allow_ok;
  reg [1:0] rstate;
  reg [31:0] timer;
  reg [31:0] wait_cycles;
  reg reply_text;
  reg [7:0] reply_byte;
  reg [3:0] idx;
  reg [7:0] tx_sum;

  reg frame_done;
  reg ping_bc;
  reg addressed;
  reg sum_ok;
  reg [39:0] delay_calc;
  reg [7:0] cur_byte;

  function [7:0] hex;
    input [3:0] n;
    begin
      if (n < 4'ha)
        hex = 8'h30 + {4'h0, n};
      else
        hex = 8'h37 + {4'h0, n};
    end
  endfunction

  always @* begin
    frame_done = rx_valid && (rstate == R_IDLE) && (pstate == P_CHK);
    sum_ok = (rx_data == ~p_sum);
    // Fixed broadcast identification frame, matched byte for byte
    ping_bc = !p_ext && (p_addr == `BCAST_ADDR) &&
      (p_arg == `ARG_PING) && (rx_data == `PING_BC_CHK);
    addressed = ping_bc ||
      (sum_ok && (p_addr[7:2] == unit_id));
    // Least wait rounds up to whole cycles
    delay_calc = ({32'h0, resp_delay} * CLK40 + UNIT_ROUND) >> 15;
  end

  // Identification text: prefix, "ID=aa,C=cc", checksum
  always @* begin
    case (idx)
      4'h0: cur_byte = `PFX_VAR;
      4'h1: cur_byte = 8'h49;
      4'h2: cur_byte = 8'h44;
      4'h3: cur_byte = 8'h3d;
      4'h4: cur_byte = hex({unit_id[5:2]});
      4'h5: cur_byte = hex({unit_id[1:0], `AXIS_BOTH});
      4'h6: cur_byte = 8'h2c;
      4'h7: cur_byte = 8'h43;
      4'h8: cur_byte = 8'h3d;
      4'h9: cur_byte = hex({line_emul, temporary_half_duplex_mode, 2'h0});
      4'ha: cur_byte = hex(4'h0);
      default: cur_byte = ~tx_sum;
    endcase
  end

  always @(posedge clock) begin
    if (srst) begin
      prim_delay <= `FACTORY_DELAY;
      prim_emul <= FACTORY_EMUL;
      edit_delay <= `FACTORY_DELAY;
      edit_emul <= FACTORY_EMUL;
      resp_delay <= `FACTORY_DELAY;
      line_emul <= FACTORY_EMUL;
      temporary_half_duplex_mode <= 1'b0;
      streaming <= 1'b0;
      window_open <= 1'b1;
      win_cnt <= 32'h0;
      pstate <= P_IDLE;
      p_ext <= 1'b0;
      p_addr <= 8'h00;
      p_arg <= 8'h00;
      p_param <= 8'h00;
      p_sum <= 8'h00;
      allow_ok <= 1'b0;
      rstate <= R_IDLE;
      timer <= 32'h0;
      wait_cycles <= 32'h0;
      reply_text <= 1'b0;
      reply_byte <= 8'h00;
      idx <= 4'h0;
      tx_sum <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      commit_busy <= 1'b0;
    end else begin
      // Startup listening window, then streaming if emulation applies
      if (window_open) begin
        if (win_cnt >= WIN32 - 32'h1) begin
          window_open <= 1'b0;
          streaming <= line_emul && !temporary_half_duplex_mode;
        end else begin
          win_cnt <= win_cnt + 32'h1;
        end
      end

      // Parser; bytes arriving while a reply is pending are dropped
      if (rx_valid && rstate == R_IDLE && !streaming) begin
        case (pstate)
          P_IDLE: begin
            // Fill bytes and stray data fall out here
            if (rx_data == `PFX_LONG || rx_data == `PFX_EXT) begin
              p_ext <= (rx_data == `PFX_EXT);
              pstate <= P_ADDR;
            end
          end
          P_ADDR: begin
            p_addr <= rx_data;
            p_sum <= rx_data;
            pstate <= P_ARG;
          end
          P_ARG: begin
            p_arg <= rx_data;
            p_sum <= p_sum + rx_data;
            pstate <= p_ext ? P_PARAM : P_CHK;
          end
          P_PARAM: begin
            p_param <= rx_data;
            p_sum <= p_sum + rx_data;
            pstate <= P_CHK;
          end
          default: pstate <= P_IDLE;
        endcase
      end

      // Command execution
      if (frame_done && !streaming && addressed) begin
        allow_ok <= 1'b0;
        wait_cycles <= delay_calc[31:0];
        reply_text <= 1'b0;
        reply_byte <= `ACK_BYTE;
        timer <= 32'h0;
        idx <= 4'h0;
        tx_sum <= 8'h00;
        if (p_ext) begin
          if (p_arg == `ARG_DELAY) begin
            // Full 0..255 range; takes effect now, kept only if committed
            edit_delay <= p_param;
            resp_delay <= p_param;
            rstate <= R_DELAY;
          end
        end else begin
          case (p_arg)
            `ARG_BREAK: begin
              // Only both-axes breaks in the window switch; else no effect
              if (window_open && line_emul &&
                  p_addr[1:0] == `AXIS_BOTH)
                temporary_half_duplex_mode <= 1'b1;
            end
            `ARG_RESET: begin
              // Re-initialise without reply; uncommitted edits are lost
              resp_delay <= prim_delay;
              line_emul <= prim_emul;
              edit_delay <= prim_delay;
              edit_emul <= prim_emul;
              temporary_half_duplex_mode <= 1'b0;
              streaming <= 1'b0;
              window_open <= 1'b1;
              win_cnt <= 32'h0;
            end
            `ARG_PING: begin
              reply_text <= 1'b1;
              rstate <= R_DELAY;
            end
            `ARG_ALLOW: begin
              allow_ok <= 1'b1;
              rstate <= R_DELAY;
            end
            `ARG_COMMIT: begin
              if (allow_ok) begin
                rstate <= R_FLASH;
                commit_busy <= 1'b1;
              end else begin
                reply_byte <= `NAK_BYTE;
                rstate <= R_DELAY;
              end
            end
            `ARG_EMUL_ON: begin
              edit_emul <= 1'b1;
              rstate <= R_DELAY;
            end
            `ARG_EMUL_OFF: begin
              edit_emul <= 1'b0;
              rstate <= R_DELAY;
            end
            default: begin
            end
          endcase
        end
      end
      if (frame_done)
        pstate <= P_IDLE;

      // Reply sequencing
      case (rstate)
        R_FLASH: begin
          // Segment copy modelled as a fixed busy time before the answer
          if (timer >= COMMIT32 - 32'h1) begin
            prim_delay <= edit_delay;
            prim_emul <= edit_emul;
            commit_busy <= 1'b0;
            timer <= 32'h0;
            rstate <= R_DELAY;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        R_DELAY: begin
          if (timer >= wait_cycles) begin
            timer <= 32'h0;
            rstate <= R_SEND;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        R_SEND: begin
          if (!tx_valid) begin
            tx_data <= reply_text ? cur_byte : reply_byte;
            tx_valid <= 1'b1;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_sum <= tx_sum + tx_data;
            idx <= idx + 4'h1;
            if (!reply_text || idx == `PING_LAST)
              rstate <= R_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: sensor_maint_sva.sv */
// Checker for the maintenance command handler, watching its ports only.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sensor_maint_chk #(
  parameter CLK_HZ = 125000000,
  parameter COMMIT_CYCLES = 20
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Byte link
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire [5:0] unit_id,
  // Operating state
  input wire streaming,
  input wire temporary_half_duplex_mode,
  input wire line_emul,
  input wire [7:0] resp_delay,
  input wire commit_busy
);
  localparam int BUSY_MAX = COMMIT_CYCLES + 4;
  logic [31:0] since_rx = 32'h0;
  logic [7:0] d_at_rx = 8'h00;
  logic armed = 1'b0;
  longint lo;
  // Only the first byte of a reply is timed; later bytes follow the host
  always @(posedge clock) begin
    since_rx <= rx_valid ? 32'h0 : since_rx + 32'h1;
    armed <= rx_valid ? 1'b1 : (tx_valid ? 1'b0 : armed);
    if (rx_valid) d_at_rx <= resp_delay;
  end
  assign lo = (longint'(resp_delay) * CLK_HZ) / 32768;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence busy_on;
    $rose(commit_busy);
  endsequence
  sequence busy_hold;
    commit_busy [*8];
  endsequence
  a_reset_quiet: assert property ($fell(srst) |-> !tx_valid
    && resp_delay == 8'h00 && !commit_busy && !temporary_half_duplex_mode)
    else $error("state not cleared by reset");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte not held");
  a_stream_quiet: assert property (streaming |-> !tx_valid)
    else $error("reply while streaming");
  a_busy_silent: assert property (commit_busy |-> !tx_valid)
    else $error("reply during commit");
  a_busy_span: assert property (busy_on |->
    busy_hold ##[1:BUSY_MAX] !commit_busy) else $error("commit busy span");
  a_busy_cause: assert property (busy_on |-> since_rx <= 6)
    else $error("commit without a frame");
  a_temp_cause: assert property (
    $rose(temporary_half_duplex_mode) |-> since_rx <= 6 && !streaming)
    else $error("half duplex without a frame");
  a_reply_wait: assert property ($rose(tx_valid) && armed
    && resp_delay == d_at_rx |-> since_rx >= lo
    && since_rx <= lo + COMMIT_CYCLES + 8) else $error("reply wait");
endmodule
bind sensor_maintenance_command_handler sensor_maint_chk #(
  .CLK_HZ(CLK_HZ), .COMMIT_CYCLES(COMMIT_CYCLES)) chk_u (.clock, .srst,
  .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready, .unit_id,
  .streaming, .temporary_half_duplex_mode, .line_emul, .resp_delay,
  .commit_busy);
`default_nettype wire

/* File: host_link_model.sv */
// Host side of the byte link: takes reply bytes, stalling on request.
// Assumes tx_valid and tx_data hold until tx_ready is seen high.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Reply bytes
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output var logic tx_ready,
  // Stall control
  input wire logic slow
);
  logic [1:0] phase = 2'h0;
  logic [7:0] got[$];
  always @(posedge clock) begin
    phase <= phase + 2'h1;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // A slow host takes one byte in four cycles
  assign tx_ready = !srst && (!slow || phase == 2'h3);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the maintenance command handler with a host model.
// Assumes short window and commit counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ADR = {6'h15, 2'h3};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic [5:0] unit_id = 6'h15;
  logic slow = 1'b0;
  logic [7:0] tx_data, resp_delay, sum;
  logic tx_valid, tx_ready, streaming, temp, line_emul, commit_busy;
  logic busy_seen = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int t;
  // Factory image streams, so the startup break has something to stop
  sensor_maintenance_command_handler #(.WINDOW_CYCLES(50),
    .COMMIT_CYCLES(20), .FACTORY_EMUL(1'b1)) dut_u (.clock(clock),
    .srst(srst),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .unit_id(unit_id),
    .streaming(streaming), .temporary_half_duplex_mode(temp),
    .line_emul(line_emul), .resp_delay(resp_delay),
    .commit_busy(commit_busy));
  host_link_model host_u (.clock(clock), .srst(srst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  initial forever #4 clock = ~clock;
  always @(posedge clock) if (commit_busy === 1'b1) busy_seen <= 1'b1;
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clock);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
  endtask
  // Bad is xored into the checksum to spoil it on purpose
  task automatic frame(input logic [7:0] adr, arg, p, bad, input bit ext);
    send(ext ? 8'haf : 8'hac);
    send(adr);
    send(arg);
    if (ext) send(p);
    send(~(adr + arg + (ext ? p : 8'h00)) ^ bad);
    host_u.got.delete();
  endtask
  task automatic reply(input int n, input logic [7:0] first);
    t = 0;
    while (host_u.got.size() < n && t < 40000) begin
      @(posedge clock);
      t++;
    end
    check("reply count", host_u.got.size(), n);
    check("reply byte", host_u.got[0], first);
  endtask
  task automatic none(input string what, input int n);
    repeat (n) @(posedge clock);
    check(what, host_u.got.size(), 0);
  endtask
  task automatic brk;
    frame(ADR, 8'h02, 8'h00, 8'h00, 1'b0);
    send(8'hff);
    send(8'hff);
  endtask
  task automatic t_break;
    // Breaks already run while reset holds, as a host would at power-up
    fork
      begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
      end
      repeat (3) brk();
    join
    check("half duplex", temp, 1'b1);
    check("factory delay", resp_delay, 8'h00);
    check("line mode", line_emul, 1'b1);
    brk();
    none("break reply", 200);
    // The window has closed by now, so silence means the escape held
    check("silent line", streaming, 1'b0);
    check("half duplex kept", temp, 1'b1);
    $display("done break");
  endtask
  task automatic t_ping;
    slow <= 1'b1;
    host_u.got.delete();
    send(8'hac);
    send(8'h03);
    send(8'hb7);
    send(8'h98);
    reply(12, 8'ha0);
    sum = 8'h00;
    for (int i = 0; i < 11; i++) sum += host_u.got[i];
    sum = ~sum;
    check("ping checksum", host_u.got[11], sum);
    check("ping id high", host_u.got[4], 8'h35);
    check("ping id low", host_u.got[5], 8'h37);
    check("ping mode", host_u.got[9], 8'h43);
    slow <= 1'b0;
    $display("done ping");
  endtask
  task automatic t_commit;
    frame(ADR, 8'hcd, 8'h01, 8'h00, 1'b1);
    reply(1, 8'h06);
    check("zero wait", t <= 6, 1'b1);
    check("active delay", resp_delay, 8'h01);
    // Commit the half-duplex line mode so that the later reset command stays quiet
    frame(ADR, 8'hc2, 8'h00, 8'h00, 1'b0);
    reply(1, 8'h06);
    check("active mode kept", line_emul, 1'b1);
    frame(ADR, 8'h01, 8'h00, 8'h00, 1'b0);
    reply(1, 8'h06);
    check("delay wait", t >= 3815 && t <= 3830, 1'b1);
    frame(ADR, 8'h00, 8'h00, 8'h00, 1'b0);
    reply(1, 8'h06);
    check("commit busy", busy_seen, 1'b1);
    frame(ADR, 8'h00, 8'h00, 8'h00, 1'b0);
    reply(1, 8'h15);
    $display("done commit");
  endtask
  task automatic t_reset;
    frame(ADR, 8'hcd, 8'h09, 8'h00, 1'b1);
    reply(1, 8'h06);
    frame(ADR, 8'h03, 8'h00, 8'h00, 1'b0);
    none("reset reply", 6000);
    check("reloaded delay", resp_delay, 8'h01);
    check("half duplex ended", temp, 1'b0);
    check("committed mode", line_emul, 1'b0);
    frame(ADR, 8'h01, 8'h00, 8'h40, 1'b0);
    none("bad checksum", 6000);
    frame(ADR ^ 8'h04, 8'h01, 8'h00, 8'h00, 1'b0);
    none("foreign unit", 6000);
    frame(ADR, 8'hc3, 8'h00, 8'h00, 1'b0);
    reply(1, 8'h06);
    check("mode not yet active", line_emul, 1'b0);
    frame(ADR, 8'h00, 8'h00, 8'h00, 1'b0);
    reply(1, 8'h15);
    $display("done reset");
  endtask
  task automatic t_stream;
    // Power cycle with no break: factory image comes back and streams
    srst <= 1'b1;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    host_u.got.delete();
    none("reset quiet", 60);
    check("streaming", streaming, 1'b1);
    check("factory mode", line_emul, 1'b1);
    check("factory delay again", resp_delay, 8'h00);
    check("half duplex off", temp, 1'b0);
    frame(ADR, 8'h01, 8'h00, 8'h00, 1'b0);
    none("stream reply", 200);
    $display("done stream");
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    $display("[FAIL] watchdog expected end seen hang");
    give_verdict();
  end
  initial begin
    t_break();
    t_ping();
    t_commit();
    t_reset();
    t_stream();
    give_verdict();
  end
endmodule
`default_nettype wire
